// ### sbt_params.svh
// Constants for the status byte, trigger and self-test block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

`define SBT_STB_BUSY_BIT   0
`define SBT_STB_LIST_BIT   1
`define SBT_STB_ERRQ_BIT   2
`define SBT_STB_QUES_BIT   3
`define SBT_STB_MAV_BIT    4
`define SBT_STB_ESB_BIT    5
`define SBT_STB_MSS_BIT    6
`define SBT_STB_OPER_BIT   7

`define SBT_SRE_RESET      8'h00
`define SBT_SRE_WR_MASK    8'hBF

`define SBT_TST_PASS       8'h00
`define SBT_TST_COMMON     8'h17
`define SBT_TST_DIAG       8'hF7
`define SBT_TST_LAST_IDX   3'h7

`endif

// ### sbt_pkg.sv
// Types shared by the status byte, trigger and self-test block.
// Assumes sbt_params.svh is compiled alongside.
package sbt_pkg;
  typedef enum logic [2:0] {
    SBT_CMD_SRE_WR,
    SBT_CMD_SRE_RD,
    SBT_CMD_STB_RD,
    SBT_CMD_TRG,
    SBT_CMD_TST,
    SBT_CMD_DIAG_TST,
    SBT_CMD_WAI,
    SBT_CMD_OTHER
  } sbt_cmd_t;

  typedef enum {
    SBT_ST_IDLE,
    SBT_ST_TEST,
    SBT_ST_WAIT
  } sbt_state_t;

  typedef enum {
    SBT_TS_IDLE,
    SBT_TS_STEP,
    SBT_TS_WAIT
  } sbt_tst_state_t;
endpackage

// ### sbt_selftest.sv
// Self-test sequencer: runs every selected subtest in turn and ORs failures.
// Assumes the outside runs subtest sub_index_ff on sub_start_ff and answers sub_done.
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_selftest (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       diag,
  input  wire logic       sub_done,
  input  wire logic       sub_fail,
  output logic            sub_start_ff,
  output logic [2:0]      sub_index_ff,
  output logic            done_ff,
  output logic [7:0]      result_ff
);
  import sbt_pkg::*;

  sbt_tst_state_t state_ff;
  sbt_tst_state_t nxt_state;
  logic [7:0]     mask_ff;
  logic [7:0]     nxt_mask;
  logic [2:0]     nxt_index;
  logic [7:0]     nxt_result;
  logic           nxt_start;
  logic           nxt_done;

  // A failing subtest never ends the run; each one is visited in order.
  always_comb begin
    nxt_state  = state_ff;
    nxt_mask   = mask_ff;
    nxt_index  = sub_index_ff;
    nxt_result = result_ff;
    nxt_start  = 1'b0;
    nxt_done   = 1'b0;
    unique case (state_ff)
      SBT_TS_IDLE: begin
        if (start) begin
          nxt_mask   = diag ? `SBT_TST_DIAG : `SBT_TST_COMMON;
          nxt_index  = 3'h0;
          nxt_result = `SBT_TST_PASS;
          nxt_state  = SBT_TS_STEP;
        end
      end
      SBT_TS_STEP: begin
        if (mask_ff[sub_index_ff]) begin
          nxt_start = 1'b1;
          nxt_state = SBT_TS_WAIT;
        end else if (sub_index_ff == `SBT_TST_LAST_IDX) begin
          nxt_done  = 1'b1;
          nxt_state = SBT_TS_IDLE;
        end else begin
          nxt_index = sub_index_ff + 3'h1;
        end
      end
      SBT_TS_WAIT: begin
        if (sub_done) begin
          nxt_result = result_ff | (sub_fail ? (8'h01 << sub_index_ff) : 8'h00);
          if (sub_index_ff == `SBT_TST_LAST_IDX) begin
            nxt_done  = 1'b1;
            nxt_state = SBT_TS_IDLE;
          end else begin
            nxt_index = sub_index_ff + 3'h1;
            nxt_state = SBT_TS_STEP;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= SBT_TS_IDLE;
      mask_ff      <= 8'h00;
      sub_index_ff <= 3'h0;
      result_ff    <= `SBT_TST_PASS;
      sub_start_ff <= 1'b0;
      done_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      mask_ff      <= nxt_mask;
      sub_index_ff <= nxt_index;
      result_ff    <= nxt_result;
      sub_start_ff <= nxt_start;
      done_ff      <= nxt_done;
    end
  end

  a_tst_subset: assert property (@(posedge clk) disable iff (!reset_n)
    done_ff |-> ((result_ff & ~mask_ff) == 8'h00))
    else $error("self-test reported a subtest that was not run");
endmodule

// ### sbt_core.sv
// Status byte, service request, bus trigger, self-test and wait-to-continue logic.
// Assumes a parser ahead of it that decodes common commands into single-cycle requests.
//
// What this block does
// - Service-request mask takes 0 to 255; bit 6 is never stored.
// - Masked status bits are ORed into status byte bit 6.
// - Status bits: OPER 7, MSS 6, ESB 5, MAV 4, QUES 3, ERRQ 2, LIST 1, BUSY 0.
// - Mask readback returns the programmed mask.
// - Status query returns MSS in bit 6 and clears nothing.
// - MSS is set while any enabled reason exists, regardless of reads.
// - Serial poll returns RQS in bit 6 and then resets RQS, unless MSS rises in the same cycle.
// - Status bits clear only when their causes go away, never on read.
// - Bus trigger fires only when armed, source is bus, and waiting flag set.
// - A fired trigger applies stored levels and clears the waiting flag.
// - With continuous initiation the waiting flag is set again at once.
// - Trigger command and bus trigger act only when addressed as listener.
// - Triggers are ignored while the output is off.
// - Self-test returns zero on pass, else one bit per failed subtest.
// - Every selected subtest runs even after a failure; failures are ORed.
// - Common test covers bits 0,1,2,4; diagnostic test also 5,6,7.
// - Wait command holds off all later commands until earlier ones finish.
// - Wait ends once earlier commands finished and output levels settled.
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_core #(
  parameter int LVL_W = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              cmd_valid,
  input  wire sbt_pkg::sbt_cmd_t cmd_code,
  input  wire logic [7:0]        cmd_data,
  input  wire logic              oper_summary,
  input  wire logic              event_summary,
  input  wire logic              msg_available,
  input  wire logic              ques_summary,
  input  wire logic              error_queue_pending_flag,
  input  wire logic              list_running,
  input  wire logic              busy,
  input  wire logic              serial_poll,
  input  wire logic              listener_addressed,
  input  wire logic              bus_get,
  input  wire logic              trig_source_bus,
  input  wire logic              init_cont,
  input  wire logic              init_imm,
  input  wire logic              output_on,
  input  wire logic [LVL_W-1:0]  trig_volt_level,
  input  wire logic [LVL_W-1:0]  trig_curr_level,
  input  wire logic              ops_pending,
  input  wire logic              levels_settled,
  input  wire logic              sub_done,
  input  wire logic              sub_fail,
  output logic                   cmd_ready_ff,
  output logic                   exec_ff,
  output logic                   rsp_valid_ff,
  output logic [7:0]             rsp_data_ff,
  output logic                   poll_valid_ff,
  output logic [7:0]             poll_data_ff,
  output logic                   wtg_ff,
  output logic                   apply_ff,
  output logic [LVL_W-1:0]       volt_out_ff,
  output logic [LVL_W-1:0]       curr_out_ff,
  output logic                   srq_out_ff,
  output logic                   srq_oe_n_ff,
  output logic                   sub_start_ff,
  output logic [2:0]             sub_index_ff
);
  import sbt_pkg::*;

  logic [7:0]       sre_ff;
  logic [7:0]       nxt_sre;
  logic             rqs_ff;
  logic             nxt_rqs;
  logic             mss_prev_ff;
  logic [7:0]       cause;
  logic             mss;
  logic             mss_rise;
  logic             nxt_wtg;
  logic             nxt_apply;
  logic [LVL_W-1:0] nxt_volt;
  logic [LVL_W-1:0] nxt_curr;
  sbt_state_t       state_ff;
  sbt_state_t       nxt_state;
  logic             nxt_ready;
  logic             nxt_exec;
  logic             nxt_rsp_valid;
  logic [7:0]       nxt_rsp_data;
  logic             nxt_poll_valid;
  logic [7:0]       nxt_poll_data;
  logic             take;
  logic             trg_req;
  logic             fire;
  logic             tst_start;
  logic             tst_diag;
  logic             tst_done;
  logic [7:0]       tst_result;

  // Builds the status byte with a chosen bit in the summary position.
  function automatic logic [7:0] status_byte(input logic [7:0] c, input logic summary);
    logic [7:0] b;
    b                   = c;
    b[`SBT_STB_MSS_BIT] = summary;
    return b;
  endfunction

  assign cause = {oper_summary, 1'b0, event_summary, msg_available,
                  ques_summary, error_queue_pending_flag, list_running, busy};
  assign mss      = |(cause & sre_ff);
  assign mss_rise = mss & ~mss_prev_ff;
  assign take     = cmd_valid & cmd_ready_ff;

  // Status byte and service request.
  always_comb begin
    nxt_sre = sre_ff;
    if (take && cmd_code == SBT_CMD_SRE_WR) begin
      nxt_sre = cmd_data & `SBT_SRE_WR_MASK;
    end
    nxt_rqs = rqs_ff;
    if (serial_poll) begin
      nxt_rqs = 1'b0;
    end
    if (mss_rise) begin
      nxt_rqs = 1'b1;
    end
    nxt_poll_valid = serial_poll;
    nxt_poll_data  = serial_poll ? status_byte(cause, rqs_ff) : poll_data_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sre_ff        <= `SBT_SRE_RESET;
      rqs_ff        <= 1'b0;
      mss_prev_ff   <= 1'b0;
      poll_valid_ff <= 1'b0;
      poll_data_ff  <= 8'h00;
      srq_out_ff    <= 1'b0;
      srq_oe_n_ff   <= 1'b1;
    end else begin
      sre_ff        <= nxt_sre;
      rqs_ff        <= nxt_rqs;
      mss_prev_ff   <= mss;
      poll_valid_ff <= nxt_poll_valid;
      poll_data_ff  <= nxt_poll_data;
      srq_out_ff    <= 1'b0;
      srq_oe_n_ff   <= ~nxt_rqs;
    end
  end

  // Trigger subsystem.
  assign trg_req = (take && cmd_code == SBT_CMD_TRG) | bus_get;
  assign fire    = trg_req & listener_addressed & trig_source_bus
                   & wtg_ff & output_on;

  always_comb begin
    nxt_wtg   = wtg_ff | init_imm | init_cont;
    nxt_apply = fire;
    nxt_volt  = volt_out_ff;
    nxt_curr  = curr_out_ff;
    if (fire) begin
      nxt_wtg  = init_cont;
      nxt_volt = trig_volt_level;
      nxt_curr = trig_curr_level;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wtg_ff      <= 1'b0;
      apply_ff    <= 1'b0;
      volt_out_ff <= '0;
      curr_out_ff <= '0;
    end else begin
      wtg_ff      <= nxt_wtg;
      apply_ff    <= nxt_apply;
      volt_out_ff <= nxt_volt;
      curr_out_ff <= nxt_curr;
    end
  end

  // Command sequencing, queries and wait-to-continue.
  always_comb begin
    nxt_state     = state_ff;
    nxt_ready     = cmd_ready_ff;
    nxt_exec      = 1'b0;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data  = rsp_data_ff;
    tst_start     = 1'b0;
    tst_diag      = 1'b0;
    unique case (state_ff)
      SBT_ST_IDLE: begin
        nxt_ready = 1'b1;
        if (take) begin
          unique case (cmd_code)
            SBT_CMD_SRE_RD: begin
              nxt_rsp_valid = 1'b1;
              nxt_rsp_data  = sre_ff;
            end
            SBT_CMD_STB_RD: begin
              nxt_rsp_valid = 1'b1;
              nxt_rsp_data  = status_byte(cause, mss);
            end
            SBT_CMD_TST, SBT_CMD_DIAG_TST: begin
              tst_start = 1'b1;
              tst_diag  = (cmd_code == SBT_CMD_DIAG_TST);
              nxt_ready = 1'b0;
              nxt_state = SBT_ST_TEST;
            end
            SBT_CMD_WAI: begin
              nxt_ready = 1'b0;
              nxt_state = SBT_ST_WAIT;
            end
            SBT_CMD_OTHER: begin
              nxt_exec = 1'b1;
            end
            SBT_CMD_SRE_WR, SBT_CMD_TRG: begin
              nxt_exec = 1'b0;
            end
          endcase
        end
      end
      SBT_ST_TEST: begin
        if (tst_done) begin
          nxt_rsp_valid = 1'b1;
          nxt_rsp_data  = tst_result;
          nxt_ready     = 1'b1;
          nxt_state     = SBT_ST_IDLE;
        end
      end
      SBT_ST_WAIT: begin
        if (!ops_pending && levels_settled) begin
          nxt_ready = 1'b1;
          nxt_state = SBT_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff     <= SBT_ST_IDLE;
      cmd_ready_ff <= 1'b0;
      exec_ff      <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= 8'h00;
    end else begin
      state_ff     <= nxt_state;
      cmd_ready_ff <= nxt_ready;
      exec_ff      <= nxt_exec;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff  <= nxt_rsp_data;
    end
  end

  sbt_selftest u_selftest (
    .clk          (clk),
    .reset_n      (reset_n),
    .start        (tst_start),
    .diag         (tst_diag),
    .sub_done     (sub_done),
    .sub_fail     (sub_fail),
    .sub_start_ff (sub_start_ff),
    .sub_index_ff (sub_index_ff),
    .done_ff      (tst_done),
    .result_ff    (tst_result)
  );

  sequence s_wai_taken;
    cmd_valid && cmd_ready_ff && cmd_code == SBT_CMD_WAI;
  endsequence

  sequence s_idle_done;
    !ops_pending && levels_settled;
  endsequence

  a_mask_no_bit6: assert property (@(posedge clk) disable iff (!reset_n)
    !sre_ff[`SBT_STB_MSS_BIT])
    else $error("service-request mask holds bit 6");

  a_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
    (take && cmd_code == SBT_CMD_SRE_WR) |=> sre_ff == ($past(cmd_data) & 8'hBF))
    else $error("mask write not stored");

  a_mask_readback: assert property (@(posedge clk) disable iff (!reset_n)
    (take && cmd_code == SBT_CMD_SRE_RD) |=> rsp_valid_ff && rsp_data_ff == $past(sre_ff))
    else $error("mask readback wrong");

  a_stb_query: assert property (@(posedge clk) disable iff (!reset_n)
    (take && cmd_code == SBT_CMD_STB_RD) |=> rsp_valid_ff
      && rsp_data_ff[6] == $past(|(cause & sre_ff))
      && {rsp_data_ff[7], rsp_data_ff[5:0]} == $past({cause[7], cause[5:0]})
      && (rqs_ff || !$past(rqs_ff) || $past(serial_poll)))
    else $error("status query wrong or disturbed RQS");

  a_poll_clears: assert property (@(posedge clk) disable iff (!reset_n)
    (serial_poll && !mss_rise) |=> !rqs_ff && poll_data_ff[6] == $past(rqs_ff))
    else $error("serial poll did not report and reset RQS");

  a_rqs_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    mss_rise |=> rqs_ff && !srq_oe_n_ff)
    else $error("new service reason lost or line not driven");

  a_trig_gated: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(apply_ff) |-> $past(wtg_ff && output_on && listener_addressed && trig_source_bus))
    else $error("trigger fired without all conditions");

  a_trig_single: assert property (@(posedge clk) disable iff (!reset_n)
    (fire && !init_cont) |=> !wtg_ff && volt_out_ff == $past(trig_volt_level))
    else $error("single trigger did not apply and clear");

  a_trig_rearm: assert property (@(posedge clk) disable iff (!reset_n)
    (fire && init_cont) |=> wtg_ff && apply_ff)
    else $error("continuous trigger did not rearm");

  a_wai_hold: assert property (@(posedge clk) disable iff (!reset_n)
    s_wai_taken |=> !cmd_ready_ff until_with (!ops_pending && levels_settled))
    else $error("command accepted while waiting");

  a_wai_release: assert property (@(posedge clk) disable iff (!reset_n)
    (state_ff == SBT_ST_WAIT) ##0 s_idle_done |=> cmd_ready_ff)
    else $error("wait not released after completion");
endmodule

// ### sbt_ctrl_model.sv
// Model of the remote controller and of the subtest hardware.
// Assumes one clock and one caller of send() at a time.
`timescale 1ns/1ps
module sbt_ctrl_model (
  input  wire logic         clk,
  input  wire logic         cmd_ready_ff,
  input  wire logic         sub_start_ff,
  input  wire logic [2:0]   sub_index_ff,
  input  wire logic [7:0]   fail_mask,
  input  wire logic         slow,
  output sbt_pkg::sbt_cmd_t cmd_code,
  output logic              cmd_valid,
  output logic [7:0]        cmd_data,
  output logic              sub_done,
  output logic              sub_fail
);
  import sbt_pkg::*;
  logic [2:0] pend;
  logic       fin;

  initial begin
    cmd_valid = 1'b0;
    cmd_code  = SBT_CMD_OTHER;
    cmd_data  = 8'h00;
    sub_done  = 1'b0;
    sub_fail  = 1'b0;
    pend      = 3'h0;
  end

  // The request is held until an edge sees ready; released code and data are inverted.
  task automatic send(input sbt_cmd_t code, input logic [7:0] data);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_data  <= data;
    do @(posedge clk); while (cmd_ready_ff !== 1'b1);
    cmd_valid <= 1'b0;
    cmd_code  <= sbt_cmd_t'(~code);
    cmd_data  <= ~data;
  endtask

  // A subtest answers at once or three cycles late, failing per fail_mask.
  assign fin = slow ? pend[2] : sub_start_ff;
  always @(posedge clk) begin
    pend     <= {pend[1:0], sub_start_ff};
    sub_done <= fin;
    sub_fail <= fin & fail_mask[sub_index_ff];
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the status byte, trigger and self-test block.
// Assumes sbt_core, sbt_selftest and sbt_ctrl_model are compiled before it.
`timescale 1ns/1ps
module tb_top;
  import sbt_pkg::*;
  typedef struct {logic [7:0] mask, cause, service_request_mask, stb;} sbt_row_t;
  typedef struct {logic diag, slw; logic [7:0] fail, res;} sbt_tst_row_t;
  logic        clk, reset_n, serial_poll, listener_addressed, bus_get, trig_source_bus;
  logic        init_cont, init_imm, output_on, ops_pending, levels_settled, slow;
  logic        cmd_valid, cmd_ready_ff, exec_ff, rsp_valid_ff, poll_valid_ff;
  logic        wtg_ff, apply_ff, srq_out_ff, srq_oe_n_ff, sub_start_ff, sub_done, sub_fail;
  logic [7:0]  causes, fail_mask, cmd_data, rsp_data_ff, poll_data_ff, d;
  logic [15:0] tv, tc, volt_out_ff, curr_out_ff;
  logic [2:0]  sub_index_ff;
  sbt_cmd_t    cmd_code;
  int          n_mismatch, num_checks, n_exec, e0;
  sbt_row_t    rows[5] = '{'{8'h28, 8'h20, 8'h28, 8'h60}, '{8'hFF, 8'h00, 8'hBF, 8'h00},
                           '{8'h40, 8'h9F, 8'h00, 8'h9F}, '{8'h01, 8'h01, 8'h01, 8'h41},
                           '{8'h80, 8'h3F, 8'h80, 8'h3F}};
  sbt_tst_row_t tr[5] = '{'{1'b0, 1'b0, 8'hFF, 8'h17}, '{1'b1, 1'b1, 8'hFF, 8'hF7},
                          '{1'b0, 1'b0, 8'h00, 8'h00}, '{1'b1, 1'b0, 8'h21, 8'h21},
                          '{1'b0, 1'b1, 8'h08, 8'h00}};

  sbt_core #(.LVL_W(16)) sbt_core_i (
    .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .oper_summary(causes[7]), .event_summary(causes[5]),
    .msg_available(causes[4]), .ques_summary(causes[3]),
    .error_queue_pending_flag(causes[2]), .list_running(causes[1]), .busy(causes[0]),
    .serial_poll(serial_poll), .listener_addressed(listener_addressed), .bus_get(bus_get),
    .trig_source_bus(trig_source_bus), .init_cont(init_cont), .init_imm(init_imm),
    .output_on(output_on), .trig_volt_level(tv), .trig_curr_level(tc),
    .ops_pending(ops_pending), .levels_settled(levels_settled), .sub_done(sub_done),
    .sub_fail(sub_fail), .cmd_ready_ff(cmd_ready_ff), .exec_ff(exec_ff),
    .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff), .poll_valid_ff(poll_valid_ff),
    .poll_data_ff(poll_data_ff), .wtg_ff(wtg_ff), .apply_ff(apply_ff),
    .volt_out_ff(volt_out_ff), .curr_out_ff(curr_out_ff), .srq_out_ff(srq_out_ff),
    .srq_oe_n_ff(srq_oe_n_ff), .sub_start_ff(sub_start_ff), .sub_index_ff(sub_index_ff));

  sbt_ctrl_model sbt_ctrl_model_i (
    .clk(clk), .cmd_ready_ff(cmd_ready_ff), .sub_start_ff(sub_start_ff),
    .sub_index_ff(sub_index_ff), .fail_mask(fail_mask), .slow(slow), .cmd_code(cmd_code),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .sub_done(sub_done), .sub_fail(sub_fail));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) if (exec_ff === 1'b1) n_exec++;

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic end_test(input string name);
    $display("Test %s finished", name);
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic query(input sbt_cmd_t code, output logic [7:0] q);
    sbt_ctrl_model_i.send(code, 8'h00);
    q = 8'hXX;
    for (int i = 0; i < 400; i++) begin
      #1;
      if (rsp_valid_ff === 1'b1) begin
        q = rsp_data_ff;
        break;
      end
      @(posedge clk);
    end
  endtask

  task automatic poll(output logic [7:0] q);
    @(posedge clk);
    serial_poll <= 1'b1;
    @(posedge clk);
    serial_poll <= 1'b0;
    q = 8'hXX;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (poll_valid_ff === 1'b1) begin
        q = poll_data_ff;
        break;
      end
      @(posedge clk);
    end
  endtask

  task automatic trig(input logic via_get, input logic fire, input string what);
    logic seen;
    seen = 1'b0;
    if (via_get) begin
      @(posedge clk);
      bus_get <= 1'b1;
      @(posedge clk);
      bus_get <= 1'b0;
    end else sbt_ctrl_model_i.send(SBT_CMD_TRG, 8'h00);
    repeat (3) begin
      #1;
      if (apply_ff === 1'b1) seen = 1'b1;
      @(posedge clk);
    end
    chk_bit(what, fire, seen);
  endtask

  initial begin
    #(50 * 8000);
    n_mismatch++;
    $display("Error watchdog expected done seen timeout");
    final_report();
  end

  initial begin
    {reset_n, serial_poll, listener_addressed, bus_get, trig_source_bus} = 5'h00;
    {init_cont, init_imm, output_on, ops_pending, levels_settled, slow} = 6'h00;
    {causes, fail_mask, tv, tc} = 48'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_bit("srq idle", 1'b1, srq_oe_n_ff);
    chk_bit("wtg idle", 1'b0, wtg_ff);
    query(SBT_CMD_SRE_RD, d);
    chk_val("mask reset", 8'h00, d);
    end_test("reset");
    foreach (rows[k]) begin
      @(posedge clk);
      causes <= rows[k].cause;
      sbt_ctrl_model_i.send(SBT_CMD_SRE_WR, rows[k].mask);
      query(SBT_CMD_SRE_RD, d);
      chk_val("mask", rows[k].service_request_mask, d);
      query(SBT_CMD_STB_RD, d);
      chk_val("status", rows[k].stb, d);
      query(SBT_CMD_STB_RD, d);
      chk_val("status reread", rows[k].stb, d);
    end
    end_test("table");
    poll(d);
    chk_val("poll table", 8'h7F, d);
    @(posedge clk);
    causes <= 8'h00;
    sbt_ctrl_model_i.send(SBT_CMD_SRE_WR, 8'h10);
    @(posedge clk);
    causes <= 8'h10;
    repeat (3) @(posedge clk);
    #1;
    chk_bit("srq set", 1'b0, srq_oe_n_ff);
    chk_bit("srq low", 1'b0, srq_out_ff);
    poll(d);
    chk_val("poll rqs", 8'h50, d);
    chk_bit("srq cleared", 1'b1, srq_oe_n_ff);
    query(SBT_CMD_STB_RD, d);
    chk_val("status after poll", 8'h50, d);
    poll(d);
    chk_val("poll again", 8'h10, d);
    end_test("poll");
    @(posedge clk);
    {listener_addressed, trig_source_bus, output_on} <= 3'h7;
    tv <= 16'h1234;
    tc <= 16'h0ABC;
    trig(1'b0, 1'b0, "unarmed");
    @(posedge clk);
    init_imm <= 1'b1;
    @(posedge clk);
    init_imm <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_bit("armed", 1'b1, wtg_ff);
    trig(1'b0, 1'b1, "single");
    chk_val("volt", 16'h1234, volt_out_ff);
    chk_val("curr", 16'h0ABC, curr_out_ff);
    chk_bit("wtg clear", 1'b0, wtg_ff);
    trig(1'b0, 1'b0, "spent");
    @(posedge clk);
    init_cont <= 1'b1;
    tv <= 16'hFEDC;
    repeat (2) @(posedge clk);
    trig(1'b1, 1'b1, "bus get");
    chk_val("volt again", 16'hFEDC, volt_out_ff);
    chk_bit("rearmed", 1'b1, wtg_ff);
    trig(1'b0, 1'b1, "continuous");
    listener_addressed <= 1'b0;
    trig(1'b0, 1'b0, "not listener");
    trig(1'b1, 1'b0, "get not listener");
    {listener_addressed, output_on} <= 2'h2;
    trig(1'b0, 1'b0, "output off");
    {output_on, trig_source_bus} <= 2'h2;
    trig(1'b0, 1'b0, "source not bus");
    end_test("trigger");
    foreach (tr[k]) begin
      @(posedge clk);
      fail_mask <= tr[k].fail;
      slow <= tr[k].slw;
      query(tr[k].diag ? SBT_CMD_DIAG_TST : SBT_CMD_TST, d);
      chk_val("selftest", {8'h00, tr[k].res}, {8'h00, d});
    end
    end_test("selftest");
    @(posedge clk);
    ops_pending <= 1'b1;
    sbt_ctrl_model_i.send(SBT_CMD_WAI, 8'h00);
    e0 = n_exec;
    fork
      sbt_ctrl_model_i.send(SBT_CMD_OTHER, 8'h00);
    join_none
    repeat (8) @(posedge clk);
    ops_pending <= 1'b0;
    #1;
    chk_val("held by wait", 16'(e0), 16'(n_exec));
    repeat (4) @(posedge clk);
    #1;
    chk_val("held unsettled", 16'(e0), 16'(n_exec));
    @(posedge clk);
    levels_settled <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk_val("released", 16'(e0 + 1), 16'(n_exec));
    wait fork;
    end_test("wait");
    final_report();
  end
endmodule
